// ==== core/adc_correction_dma.v ====
// Offset/gain correction and buffer DMA for a sigma-delta converter.
// Assumes raw results arrive as one-cycle strobes synchronous to clk_i and
// that the RAM port accepts one halfword write in any cycle.
`timescale 1ns/10ps
`include "adc_correction_dma_map.vh"

module adc_correction_dma (
  // Clock and reset
  input  wire        clk_i,
  input  wire        resetn_i,
  // Register port
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  // Modulator side
  input  wire        conv_valid_i,
  input  wire [15:0] conv_data_i,
  output reg         conv_enable_o,
  output reg         neg_half_ref_o,
  output reg         vref_drive_o,
  // Pins
  input  wire [7:0]  pin_in_i,
  output reg  [7:0]  pin_digital_en_o,
  // RAM side
  output reg         mem_wr_o,
  output reg  [15:0] mem_addr_o,
  output reg  [15:0] mem_wdata_o,
  // Interrupt
  output reg         irq_o
);

  // ==========================================================
  // Constants and helpers
  localparam ST_IDLE = 3'b001;
  localparam ST_RUN  = 3'b010;
  localparam ST_STOP = 3'b100;

  function is_analog;
    input [3:0] field;
    begin
      is_analog = (field == `ANALOG_MODE);
    end
  endfunction

  // ==========================================================
  // Registers
  reg [1:0]          conv_cfg;
  reg [15:0]         offset;
  reg [15:0]         gain;
  reg [15:0]         buf_start;
  reg [15:0]         buf_length;
  reg                wrap;
  reg [31:0]         pin_config;
  reg [`FLG_W-1:0]   flags;
  reg [`FLG_W-1:0]   mask;
  reg [15:0]         sample;
  reg [2:0]          state;
  reg [15:0]         write_ptr;
  reg [15:0]         count;
  reg [11:0]         startup;
  reg                startup_done;

  wire conv_en  = conv_cfg[`CFG_ENABLE];
  wire wr_dma   = wr_i && (addr_i == `REG_DMA_CFG);
  wire dma_rst  = wr_dma && wdata_i[`DMA_RESET];
  wire dma_load = wr_dma && wdata_i[`DMA_LOAD];

  // ==========================================================
  // Correction datapath
  wire signed [16:0] sum = $signed({conv_data_i[15], conv_data_i}) +
                           $signed({offset[15], offset}); // RULE5
  // Gain is zero-extended so it multiplies as unsigned
  wire signed [33:0] prod   = sum * $signed({1'b0, gain}); // RULE8
  wire signed [33:0] scaled = prod >>> `GAIN_FRAC;
  wire               over   = scaled > $signed({18'h00000, `SAT_MAX});
  wire               under  = scaled < $signed({18'h3ffff, `SAT_MIN});
  wire [15:0]        clamped = over ? `SAT_MAX : (under ? `SAT_MIN : scaled[15:0]); // RULE6
  wire [15:0]        corrected = {clamped[15], clamped[15:1]}; // RULE7 RULE24

  // Results during the startup window are dropped; the analog front end
  // is still settling and its output is not meaningful.
  wire result = conv_valid_i && conv_en && startup_done; // RULE22

  // ==========================================================
  // DMA bookkeeping
  wire [15:0] count_next = count + 16'h0001;
  wire        at_half    = (count_next == {1'b0, buf_length[15:1]}); // RULE12
  wire        at_end     = (count_next == buf_length);
  wire        store      = result && (state == ST_RUN);
  wire        ovf_event  = result && (state == ST_STOP); // RULE16

  // ==========================================================
  // Pin input view
  wire [7:0] pin_view;
  wire [7:0] pin_analog;
  genvar g;
  generate
    for (g = 0; g < `NPINS; g = g + 1) begin : g_pin
      assign pin_analog[g] = is_analog(pin_config[4*g+3:4*g]);
      assign pin_view[g]   = pin_analog[g] ? 1'b1 : pin_in_i[g]; // RULE3
    end
  endgenerate

  // ==========================================================
  // Software registers
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      conv_cfg   <= 2'h0;
      offset     <= `OFFSET_RST; // RULE9
      gain       <= `GAIN_RST;   // RULE9
      buf_start  <= 16'h0000;
      buf_length <= 16'h0000;
      wrap       <= 1'b0;
      pin_config <= 32'hffffffff;
      mask       <= 5'h00;
    end else if (wr_i) begin
      if (addr_i == `REG_CONV_CFG) begin
        conv_cfg <= wdata_i[1:0];
      end else if (addr_i == `REG_OFFSET) begin
        offset <= wdata_i[15:0];
      end else if (addr_i == `REG_GAIN) begin
        gain <= wdata_i[15:0];
      end else if (addr_i == `REG_BUF_START) begin
        // Bit 0 forced low keeps every write halfword aligned
        buf_start <= {wdata_i[15:1], 1'b0}; // RULE23
      end else if (addr_i == `REG_BUF_LENGTH) begin
        buf_length <= wdata_i[15:0];
      end else if (addr_i == `REG_DMA_CFG) begin
        wrap <= wdata_i[`DMA_WRAP]; // RULE14
      end else if (addr_i == `REG_EVENT_MASK) begin
        mask <= wdata_i[`FLG_W-1:0];
      end else if (addr_i == `REG_PIN_CONFIG) begin
        pin_config <= wdata_i;
      end
    end
  end

  // ==========================================================
  // Startup delay after each enable
  always @(posedge clk_i) begin
    if (!resetn_i || !conv_en) begin
      startup      <= 12'h000;
      startup_done <= 1'b0;
    end else if (!startup_done) begin
      if (startup == `STARTUP_CYC - 1) begin
        startup_done <= 1'b1; // RULE22
      end else begin
        startup <= startup + 12'h001;
      end
    end
  end

  // ==========================================================
  // DMA channel
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      state     <= ST_IDLE;
      write_ptr <= 16'h0000;
      count     <= 16'h0000;
    end else if (dma_rst) begin
      state     <= ST_IDLE;
      write_ptr <= buf_start;
      count     <= 16'h0000;
    end else if (dma_load) begin
      state     <= ST_RUN; // RULE13
      write_ptr <= buf_start;
      count     <= 16'h0000;
    end else begin
      case (state)
        ST_RUN: begin
          if (!conv_en) begin
            state <= ST_IDLE; // RULE17
          end else if (store) begin
            if (at_end) begin
              if (wrap) begin
                write_ptr <= buf_start; // RULE17
                count     <= 16'h0000;
              end else begin
                state <= ST_STOP; // RULE15
              end
            end else begin
              write_ptr <= write_ptr + `PTR_STEP; // RULE23
              count     <= count_next;
            end
          end
        end
        ST_STOP: begin
          if (!conv_en) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // RAM write port
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      mem_wr_o    <= 1'b0;
      mem_addr_o  <= 16'h0000;
      mem_wdata_o <= 16'h0000;
    end else begin
      mem_wr_o <= store && !dma_rst && !dma_load;
      // Address and data move only with a real store, so they hold between writes
      if (store && !dma_rst && !dma_load) begin
        mem_addr_o  <= write_ptr;
        mem_wdata_o <= corrected; // RULE10
      end
    end
  end

  // ==========================================================
  // Event flags: a hardware set in the same cycle as a clear wins
  reg [`FLG_W-1:0] set_bits;
  reg [`FLG_W-1:0] clr_bits;
  always @* begin
    set_bits = {`FLG_W{1'b0}};
    set_bits[`FLG_OVERFLOW] = ovf_event; // RULE16
    set_bits[`FLG_SATURATE] = result && (over || under); // RULE6
    set_bits[`FLG_FULL]     = store && at_end;  // RULE15 RULE18
    set_bits[`FLG_HALF]     = store && at_half; // RULE18
    set_bits[`FLG_DATA]     = result;
    clr_bits = {`FLG_W{1'b0}};
    if (wr_i && (addr_i == `REG_EVENT_FLAGS)) begin
      clr_bits = wdata_i[`FLG_W-1:0]; // RULE20
    end
  end

  always @(posedge clk_i) begin
    if (!resetn_i) begin
      flags  <= 5'h00;
      sample <= 16'h0000;
      irq_o  <= 1'b0;
    end else begin
      flags <= (flags & ~clr_bits) | set_bits; // RULE20
      irq_o <= |(flags & mask); // RULE21
      if (result) begin
        sample <= corrected;
      end
    end
  end

  // ==========================================================
  // Analog control outputs
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      conv_enable_o    <= 1'b0;
      neg_half_ref_o   <= 1'b0;
      vref_drive_o     <= 1'b0;
      pin_digital_en_o <= 8'hff;
    end else begin
      conv_enable_o    <= conv_en;
      // Differential stage; single-ended ties the negative leg to mid reference
      neg_half_ref_o   <= conv_cfg[`CFG_SINGLE_ENDED]; // RULE1
      vref_drive_o     <= conv_en &&
                          is_analog(pin_config[4*`REF_PIN+3:4*`REF_PIN]); // RULE4
      pin_digital_en_o <= ~pin_analog; // RULE3
    end
  end

  // ==========================================================
  // Register read port, data one cycle after the strobe
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      if (addr_i == `REG_CONV_CFG) begin
        rdata_o <= {30'h00000000, conv_cfg};
      end else if (addr_i == `REG_OFFSET) begin
        rdata_o <= {16'h0000, offset};
      end else if (addr_i == `REG_GAIN) begin
        rdata_o <= {16'h0000, gain};
      end else if (addr_i == `REG_BUF_START) begin
        rdata_o <= {16'h0000, buf_start};
      end else if (addr_i == `REG_BUF_LENGTH) begin
        rdata_o <= {16'h0000, buf_length};
      end else if (addr_i == `REG_DMA_CFG) begin
        rdata_o <= {28'h0000000, state[1], wrap, 2'h0};
      end else if (addr_i == `REG_WRITE_PTR) begin
        rdata_o <= {16'h0000, write_ptr}; // RULE19
      end else if (addr_i == `REG_EVENT_FLAGS) begin
        rdata_o <= {27'h0000000, flags};
      end else if (addr_i == `REG_EVENT_MASK) begin
        rdata_o <= {27'h0000000, mask};
      end else if (addr_i == `REG_PIN_CONFIG) begin
        rdata_o <= pin_config;
      end else if (addr_i == `REG_PIN_INPUT) begin
        rdata_o <= {24'h000000, pin_view}; // RULE3
      end else if (addr_i == `REG_SAMPLE) begin
        rdata_o <= {16'h0000, sample};
      end else begin
        rdata_o <= 32'h00000000;
      end
    end else begin
      rdata_o <= 32'h00000000;
    end
  end

endmodule

// ==== core/adc_correction_dma_map.vh ====
// Register map, field positions, reset values and timing for adc_correction_dma.
// Assumes a 125 MHz system clock and a byte-addressed register port.
//
// What this block does
// (RULE1) Input stage always differential; single-ended ties negative input to half reference.
// (RULE2) Software writes zero into a pin's 4-bit field to select analog mode.
// (RULE3) Analog-mode pin does no digital function and reads as 1 in pin input.
// (RULE4) Internal reference drives reference pin only when enabled and pin is analog.
// (RULE5) Raw signed result is added to the signed 16-bit correction offset.
// (RULE6) Sum times gain, clamped to 0x7fff/0x8000, clamp sets gain saturation flag.
// (RULE7) Corrected value divided by two gives the final sample.
// (RULE8) Gain is unsigned fixed point: bit 15 integer, bits 14..0 fraction.
// (RULE9) Reset loads offset zero and gain 0x8000, a gain of one.
// (RULE10) DMA stores corrected samples, not raw results, into the RAM buffer.
// (RULE11) Software programs an even buffer start address.
// (RULE12) Buffer length counts 16-bit samples, half the byte length.
// (RULE13) Software resets the channel, then sets load; transfers begin only after load.
// (RULE14) Wrap select: 0 linear mode, 1 auto-wrap mode.
// (RULE15) Linear mode stores length samples, stops, sets buffer full flag.
// (RULE16) Linear mode: a result after stopping, before reset or disable, sets overflow.
// (RULE17) Auto-wrap reloads pointer with start at buffer end and keeps writing.
// (RULE18) Half flag when lower half filled, full flag when upper half filled.
// (RULE19) Current write address is readable in the buffer write pointer register.
// (RULE20) Event flags clear on writing 1; writing 0 has no effect.
// (RULE21) A set flag raises the interrupt only when its mask bit is 1.
// (RULE22) Converter runs continuously; re-enable waits 21 us before first result.
// (RULE23) Pointer advances two bytes per sample; each sample is one aligned halfword.
// (RULE24) Halving is an arithmetic right shift keeping the sign.
`ifndef ADC_CORRECTION_DMA_MAP_VH
`define ADC_CORRECTION_DMA_MAP_VH

// Register byte offsets
`define REG_CONV_CFG      8'h00
`define REG_OFFSET        8'h04
`define REG_GAIN          8'h08
`define REG_BUF_START     8'h0c
`define REG_BUF_LENGTH    8'h10
`define REG_DMA_CFG       8'h14
`define REG_WRITE_PTR     8'h18
`define REG_EVENT_FLAGS   8'h1c
`define REG_EVENT_MASK    8'h20
`define REG_PIN_CONFIG    8'h24
`define REG_PIN_INPUT     8'h28
`define REG_SAMPLE        8'h2c

// Converter config fields
`define CFG_ENABLE        0
`define CFG_SINGLE_ENDED  1
// DMA config fields
`define DMA_RESET         0
`define DMA_LOAD          1
`define DMA_WRAP          2
// Event flag fields
`define FLG_OVERFLOW      0
`define FLG_SATURATE      1
`define FLG_FULL          2
`define FLG_HALF          3
`define FLG_DATA          4
`define FLG_W             5

// Reset values, clamp limits and datapath constants
`define OFFSET_RST        16'h0000
`define GAIN_RST          16'h8000
`define SAT_MAX           16'h7fff
`define SAT_MIN           16'h8000
`define GAIN_FRAC         15
`define ANALOG_MODE       4'h0
`define PTR_STEP          16'h0002

// Pins: eight pins, 4-bit field each; pin 0 is the reference pin
`define NPINS             8
`define REF_PIN           0

// Startup delay after enable, rounded up to whole cycles
`define CLK_MHZ           125
`define STARTUP_NS        21000
`define STARTUP_CYC       ((`STARTUP_NS * `CLK_MHZ + 999) / 1000)

`endif

// ==== testbench/adc_correction_dma_bench.sv ====
// Self-checking bench for adc_correction_dma.
// Assumes conv_ram_model as far side and the map header on the include path.
`timescale 1ns/10ps
`include "adc_correction_dma_map.vh"
module adc_correction_dma_bench;
  logic        clk_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, req = 1'b0;
  logic [7:0]  addr_i = 8'h00, pin_in_i = 8'h00, pin_digital_en_o;
  logic [31:0] wdata_i = 32'h0, rdata_o, d;
  logic [15:0] raw = 16'h0, off, gain, conv_data_i, mem_addr_o, mem_wdata_o;
  logic        conv_valid_i, conv_enable_o, neg_half_ref_o, vref_drive_o, mem_wr_o, irq_o;
  logic        sat;
  logic [15:0] r0;
  logic [16:0] e;
  int          fails = 0, tests_run = 0, n0;
  adc_correction_dma adc_correction_dma_inst (.clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .conv_valid_i, .conv_data_i, .conv_enable_o, .neg_half_ref_o,
    .vref_drive_o, .pin_in_i, .pin_digital_en_o, .mem_wr_o, .mem_addr_o, .mem_wdata_o, .irq_o);
  conv_ram_model conv_ram_model_inst (.clk_i, .req_i(req), .raw_i(raw),
    .conv_valid_o(conv_valid_i), .conv_data_o(conv_data_i), .mem_wr_i(mem_wr_o),
    .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o));
  initial forever #4 clk_i = ~clk_i;
  // ==========
  // Tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic complete_run;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic conv(input logic [15:0] r);
    @(posedge clk_i);
    req <= 1'b1;
    raw <= r;
    @(posedge clk_i);
    req <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  // Offset, gain, clamp and halving; bit 16 tells a clamp happened
  function automatic logic [16:0] corr(input logic [15:0] r);
    logic signed [16:0] s;
    logic signed [33:0] p;
    s = $signed({r[15], r}) + $signed({off[15], off});
    p = (s * $signed({1'b0, gain})) >>> 15;
    if (p > 34'sd32767)
      return {1'b1, 16'h3fff};
    if (p < -34'sd32768)
      return {1'b1, 16'hc000};
    return {1'b0, p[16:1]};
  endfunction
  task automatic put(input logic [15:0] r, input logic [15:0] a);
    conv(r);
    e = corr(r);
    sat |= e[16];
    chk(conv_ram_model_inst.mem[a[15:1]], e[15:0]);
    chk(conv_ram_model_inst.last_addr, a);
  endtask
  // ==========
  // Tests
  initial begin
    repeat (6000) @(posedge clk_i);
    fails++;
    complete_run();
  end
  initial begin
    void'($urandom(29311));
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    pin_in_i <= 8'($urandom);
    rd(`REG_OFFSET);
    chk(d, 32'h0);
    rd(`REG_GAIN);
    chk(d, 32'h8000);
    rd(8'hfc);
    chk(d, 32'h0);
    wr(`REG_PIN_CONFIG, 32'hffff_fff0);
    wr(`REG_CONV_CFG, 32'h3);
    rd(`REG_PIN_INPUT);
    chk(d, {24'h0, pin_in_i[7:1], 1'b1});
    chk(pin_digital_en_o, 32'hfe);
    chk({conv_enable_o, neg_half_ref_o, vref_drive_o}, 32'h7);
    repeat (2700) @(posedge clk_i);
    off = 16'($urandom);
    gain = 16'($urandom);
    wr(`REG_OFFSET, {16'h0, off});
    wr(`REG_GAIN, {16'h0, gain});
    rd(`REG_GAIN);
    chk(d, {16'h0, gain});
    wr(`REG_BUF_START, 32'h100);
    wr(`REG_BUF_LENGTH, 32'h4);
    wr(`REG_DMA_CFG, 32'h1);
    n0 = conv_ram_model_inst.writes;
    conv(16'($urandom));
    chk(conv_ram_model_inst.writes - n0, 32'h0);
    wr(`REG_DMA_CFG, 32'h2);
    wr(`REG_EVENT_FLAGS, 32'h1f);
    sat = 1'b0;
    for (int i = 0; i < 4; i++) begin
      put(16'($urandom), 16'(32'h100 + 2 * i));
      rd(`REG_EVENT_FLAGS);
      chk(d[3:0], {i > 0, i == 3, sat, 1'b0});
      rd(`REG_WRITE_PTR);
      chk(d, 32'h100 + 2 * (i + (i < 3)));
    end
    n0 = conv_ram_model_inst.writes;
    // The dropped result is still corrected, so it may raise saturation too
    r0 = 16'($urandom);
    conv(r0);
    e = corr(r0);
    sat |= e[16];
    chk(conv_ram_model_inst.writes - n0, 32'h0);
    rd(`REG_SAMPLE);
    chk(d, {16'h0, e[15:0]});
    chk(irq_o, 32'h0);
    wr(`REG_EVENT_FLAGS, 32'h0);
    rd(`REG_EVENT_FLAGS);
    chk(d[4:0], {3'b111, sat, 1'b1});
    wr(`REG_EVENT_MASK, 32'h4);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 32'h1);
    wr(`REG_EVENT_FLAGS, 32'h4);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 32'h0);
    off = 16'h7fff;
    gain = 16'hffff;
    wr(`REG_OFFSET, {16'h0, off});
    wr(`REG_GAIN, {16'h0, gain});
    wr(`REG_BUF_LENGTH, 32'h2);
    wr(`REG_DMA_CFG, 32'h1);
    wr(`REG_DMA_CFG, 32'h6);
    rd(`REG_DMA_CFG);
    chk(d, 32'hc);
    wr(`REG_EVENT_FLAGS, 32'h1f);
    for (int i = 0; i < 3; i++)
      put(i == 0 ? 16'h7fff : 16'($urandom), 16'(32'h100 + 2 * (i % 2)));
    rd(`REG_EVENT_FLAGS);
    chk(d[3:0], 32'he);
    wr(`REG_CONV_CFG, 32'h0);
    n0 = conv_ram_model_inst.writes;
    conv(16'($urandom));
    chk(conv_ram_model_inst.writes - n0, 32'h0);
    chk({conv_enable_o, vref_drive_o}, 32'h0);
    complete_run();
  end
endmodule

// ==== testbench/adc_dma_properties.sv ====
// Port-level checks for adc_correction_dma.
// Assumes one clock domain and the startup count of the map header.
`timescale 1ns/10ps
`include "adc_correction_dma_map.vh"
module adc_dma_properties (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        resetn_i,
  // Observed ports
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        conv_valid_i,
  input wire logic        conv_enable_o,
  input wire logic        vref_drive_o,
  input wire logic [7:0]  pin_digital_en_o,
  input wire logic        mem_wr_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic [15:0] mem_wdata_o,
  input wire logic        irq_o
);
  // ==========
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Cycles spent enabled; saturates so a long run cannot wrap it
  logic [11:0] on_cnt;
  always @(posedge clk_i) begin
    if (!resetn_i || !conv_enable_o)
      on_cnt <= 12'h000;
    else if (on_cnt != 12'hfff)
      on_cnt <= on_cnt + 12'h001;
  end
  chk_vref_enable: assert property (
    vref_drive_o |-> conv_enable_o || $past(conv_enable_o))
    else $error("reference driven while converter off");
  chk_vref_analog: assert property (
    vref_drive_o |-> !pin_digital_en_o[0] || !$past(pin_digital_en_o[0]))
    else $error("reference driven on a digital pin");
  chk_startup_wait: assert property (
    mem_wr_o |-> on_cnt >= `STARTUP_CYC - 4)
    else $error("sample stored before startup delay");
  chk_half_range: assert property (
    mem_wr_o |-> mem_wdata_o[15] == mem_wdata_o[14])
    else $error("stored sample not halved");
  chk_store_cause: assert property (
    mem_wr_o |-> $past(conv_valid_i))
    else $error("store without a conversion");
  chk_addr_even: assert property (
    mem_wr_o |-> !mem_addr_o[0])
    else $error("odd halfword address");
  chk_addr_hold: assert property (
    !mem_wr_o |-> $stable(mem_addr_o))
    else $error("address moved without a store");
  chk_rdata_idle: assert property (
    !$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside the read cycle");
  cov_store: cover property (mem_wr_o);
  cov_irq: cover property ($rose(irq_o));
  cov_vref: cover property (vref_drive_o);
endmodule
bind adc_correction_dma adc_dma_properties adc_dma_properties_inst (.clk_i, .resetn_i,
  .rd_i, .rdata_o, .conv_valid_i, .conv_enable_o, .vref_drive_o, .pin_digital_en_o,
  .mem_wr_o, .mem_addr_o, .mem_wdata_o, .irq_o);

// ==== testbench/conv_ram_model.sv ====
// Modulator result source and RAM buffer seen by the correction block.
// Assumes the bench asks for each result one cycle ahead.
`timescale 1ns/10ps
module conv_ram_model (
  // Bench request
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic [15:0] raw_i,
  // Modulator results
  output logic             conv_valid_o,
  output logic [15:0]      conv_data_o,
  // RAM writes
  input  wire logic        mem_wr_i,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic [15:0] mem_wdata_i
);
  logic [15:0] mem [0:32767];
  logic [15:0] last_addr;
  int          writes = 0;
  initial conv_valid_o = 1'b0;
  initial conv_data_o = 16'h0000;
  // ==========
  // Behaviour
  always @(posedge clk_i) begin
    conv_valid_o <= req_i;
    // Data toggles outside a strobe so nothing leans on a stale value
    conv_data_o <= req_i ? raw_i : ~conv_data_o;
    if (mem_wr_i) begin
      mem[mem_addr_i[15:1]] <= mem_wdata_i;
      last_addr <= mem_addr_i;
      writes <= writes + 1;
    end
  end
endmodule
